// *** apb_host.sv ***
`timescale 1ns/1ps
module apb_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  ////////////////////////////////////////
  // Released address and write-data lines show inverted values so stale data is never mistaken
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
    output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // apb_host

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr, latch, irq, pin_o, pin_oe;
  logic [31:0] pwdata, prdata, rdat, r;
  logic [1:0] low;
  uart_status_pkg::pin_sources_t src;
  uart_status_pkg::chan_events_t ev [2];
  logic [2:0] q [2][$];
  logic [2:0] herr [2];
  logic [2:0] acc [2];
  int dep [2], held [2], ovr [2], blk [2];
  int mismatches, n_compared, cyc, i;
  int seed = 32'h9C1F;
  uart_status_and_output_select i_uart_status_and_output_select (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_a(ev[0]), .chan_b(ev[1]), .output_value_latch(latch), .irq_status_bits(irq),
    .low_pin_level(low), .pin_src(src), .general_out_pin_o(pin_o), .general_out_pin_oe(pin_oe));
  apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////
  task automatic tally_and_finish();
    if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    host.xfer(w, a, d, rdat, rerr);
  endtask
  // Expected status byte from the queue model
  function automatic logic [7:0] st(input int c);
    logic [2:0] e;
    e = blk[c] ? acc[c] : (q[c].size() > 0 ? q[c][0] : 3'h0);
    return {e, ovr[c] != 0, ev[c].tx_drained, ev[c].tx_space, q[c].size() == dep[c], q[c].size() > 0};
  endfunction
  task automatic sreg(input int c);
    bus(1'b0, c ? 8'h24 : 8'h04, 32'h0);
    chk(c ? "status_b" : "status_a", {24'h0, st(c)}, rdat);
  endtask
  // A read frees a slot before a load in the same cycle
  task automatic evt(input int c, input bit ld, input logic [2:0] er, input bit rq);
    @(posedge pclk);
    ev[c].rx_load <= ld;
    ev[c].rx_read <= rq;
    {ev[c].brk, ev[c].framing, ev[c].parity} <= er;
    @(posedge pclk);
    ev[c].rx_load <= 1'b0;
    ev[c].rx_read <= 1'b0;
    if (rq && q[c].size() > 0) begin
      void'(q[c].pop_front());
      if (held[c]) begin
        q[c].push_back(herr[c]);
        acc[c] |= herr[c];
        held[c] = 0;
      end
    end
    if (ld && q[c].size() < dep[c]) begin
      q[c].push_back(er);
      acc[c] |= er;
    end else if (ld && !held[c]) begin
      held[c] = 1;
      herr[c] = er;
    end else if (ld) ovr[c] = 1;
  endtask
  task automatic cmd(input int c, input logic [3:0] code);
    bus(1'b1, c ? 8'h28 : 8'h08, {24'h0, code, 4'h0});
    for (int k = 0; k < q[c].size(); k++) q[c][k] = 3'h0;
    herr[c] = 3'h0;
    acc[c] = 3'h0;
    ovr[c] = 0;
    if (code == 4'h2) begin
      q[c].delete();
      held[c] = 0;
    end
  endtask
  function automatic logic [15:0] pins(input logic [7:0] c);
    logic [7:0] o, oe;
    logic [3:0] im;
    im = {irq[4], irq[0], irq[5], irq[1]};
    o = ~latch;
    oe = 8'hFF;
    for (int k = 4; k < 8; k++) if (c[k]) begin
      o[k] = 1'b0;
      oe[k] = im[k - 4];
    end
    case (c[3:2])
      2'h1: begin
        o[3] = 1'b0;
        oe[3] = ~src.ct_out;
      end
      2'h2: o[3] = src.tx_b_1x;
      2'h3: o[3] = src.rx_b_1x;
    endcase
    case (c[1:0])
      2'h1: o[2] = src.tx_a_16x;
      2'h2: o[2] = src.tx_a_1x;
      2'h3: o[2] = src.rx_a_1x;
    endcase
    o[1:0] = low;
    return {o, oe};
  endfunction
  ////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    r = $random(seed);
    ev[0] = {5'h00, r[1:0]};
    ev[1] = {5'h00, r[3:2]};
    latch = r[15:8];
    irq = r[23:16];
    low = r[25:24];
    src = r[31:26];
    dep = '{16, 16};
    acc = '{3'h0, 3'h0};
    herr = '{3'h0, 3'h0};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    @(posedge pclk);
    #1;
    chk("pins", {16'h0, pins(8'h00)}, {16'h0, pin_o, pin_oe});
    bus(1'b0, 8'h34, 32'h0);
    chk("config_read", 32'h0, rdat);
    bus(1'b0, 8'h3C, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, rerr});
    bus(1'b1, 8'h24, 32'hFFFFFFFF);
    sreg(1);
    for (i = 0; i < 18; i++) begin
      r = $random(seed);
      evt(1, 1'b1, r[2:0], 1'b0);
      sreg(1);
    end
    for (i = 0; i < 18; i++) begin
      if (i == 6) cmd(1, 4'h4);
      evt(1, 1'b0, 3'h0, 1'b1);
      sreg(1);
    end
    bus(1'b1, 8'h40, 32'h9);
    dep[0] = 8;
    blk[1] = 1;
    for (i = 0; i < 9; i++) begin
      r = $random(seed);
      evt(0, 1'b1, r[2:0], 1'b0);
      sreg(0);
      evt(1, 1'b1, r[5:3], 1'b0);
      evt(1, 1'b0, 3'h0, 1'b1);
      sreg(1);
    end
    cmd(1, 4'h4);
    sreg(1);
    cmd(0, 4'h2);
    sreg(0);
    for (i = 0; i < 256; i++) begin
      bus(1'b1, 8'h34, {24'h0, i[7:0]});
      r = $random(seed);
      latch <= r[7:0];
      irq <= r[15:8];
      low <= r[17:16];
      src <= r[23:18];
      @(posedge pclk);
      #1;
      chk("pins", {16'h0, pins(i[7:0])}, {16'h0, pin_o, pin_oe});
    end
    tally_and_finish();
  end
endmodule // tb
bind uart_status_and_output_select uart_status_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .chan_a(chan_a), .chan_b(chan_b), .output_value_latch(output_value_latch),
  .irq_status_bits(irq_status_bits), .low_pin_level(low_pin_level), .pin_src(pin_src),
  .general_out_pin_o(general_out_pin_o), .general_out_pin_oe(general_out_pin_oe));

// *** uart_status_and_output_select.sv ***
// Summary of operation
// - Receive FIFO full flag sets when a transfer fills 8 or 16 positions.
// - A host read of the receive FIFO clears the full flag unless a held or newly loaded character refills the freed slot.
// - A held character refills the freed slot, so full stays set.
// - Receiver-ready sets on every transfer into the receive FIFO.
// - Receiver-ready clears on a read only when the FIFO becomes empty.
// - Break, framing, parity stored per character; status shows head entry bits 7:5.
// - Reset-error-status command clears break, framing and parity status.
// - Character error mode drops a character's error bits when it is read.
// - Block error mode accumulates errors until error reset or receiver reset.
// - Channel B status mirrors channel A behaviour for channel B.
// - Channel B status at offset 0x9 with the given bit layout.
// - Pins 1:0 ignore output configuration; driven by receiver, transmitter, command.
// - By default each of pins 7:2 drives the inverted output value latch bit.
// - Pins 7:2 routed to interrupt or timer signals are open-drain.
// - Config bit 7 routes inverted channel B transmit interrupt to pin 7.
// - Config bit 6 routes inverted channel A transmit interrupt to pin 6.
// - Config bit 5 routes inverted channel B receive interrupt to pin 5.
// - Config bit 4 routes inverted channel A receive interrupt to pin 4.
// - Interrupt levels on pins 7:4 are raw, not gated by the mask.
// - Output configuration at offset 0xD: bits 7:4 single, 3:2 and 1:0 pairs.
// - Pin 3 select: latch, open-drain timer, B transmit 1x, B receive 1x.
// - Pin 2 select: latch, A transmit 16x, A transmit 1x, A receive 1x.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module uart_status_and_output_select #(
  parameter int DEPTH = uart_status_pkg::DEPTH_FULL,
  parameter int LEGACY_DEPTH = uart_status_pkg::DEPTH_LEGACY
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire uart_status_pkg::chan_events_t chan_a,
  input wire uart_status_pkg::chan_events_t chan_b,
  input wire logic [7:0] output_value_latch,
  input wire logic [7:0] irq_status_bits,
  input wire logic [1:0] low_pin_level,
  input wire uart_status_pkg::pin_sources_t pin_src,
  output logic [7:0] general_out_pin_o,
  output logic [7:0] general_out_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic [5:0] idx;
  logic setup;
  logic wr_en;
  logic hit;
  logic [7:0] output_pin_configuration_q;
  logic [3:0] control_q;
  logic [31:0] prdata_q;
  logic [7:0] status_q [uart_status_pkg::CHANNELS];
  logic [31:0] rd_word;
  logic [31:0] prdata_d;
  logic cfg_wr;
  logic ctrl_wr;
  logic [7:0] output_pin_configuration_d;
  logic [3:0] control_d;

  function automatic logic is_idx(input logic [5:0] a, input logic [5:0] b);
    return a == b;
  endfunction

  // Pointers wrap at the live depth; change the legacy depth only while the FIFO is empty
  function automatic logic [uart_status_pkg::PTR_W-1:0] bump(input logic [uart_status_pkg::PTR_W-1:0] p,
    input logic step, input logic [uart_status_pkg::CNT_W-1:0] lim);
    logic [uart_status_pkg::CNT_W-1:0] nx;
    nx = uart_status_pkg::CNT_W'(p) + uart_status_pkg::CNT_W'(step);
    return (nx >= lim) ? '0 : nx[uart_status_pkg::PTR_W-1:0];
  endfunction

  assign idx = paddr[7:2];
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign hit = is_idx(idx, uart_status_pkg::IDX_STATUS_A) || is_idx(idx, uart_status_pkg::IDX_COMMAND_A)
    || is_idx(idx, uart_status_pkg::IDX_STATUS_B) || is_idx(idx, uart_status_pkg::IDX_COMMAND_B)
    || is_idx(idx, uart_status_pkg::IDX_OUT_CONFIG) || is_idx(idx, uart_status_pkg::IDX_CONTROL);

  // Write-only and command registers read back as zero
  assign rd_word = is_idx(idx, uart_status_pkg::IDX_STATUS_A) ? {24'h000000, status_q[0]} :
    is_idx(idx, uart_status_pkg::IDX_STATUS_B) ? {24'h000000, status_q[1]} :
    is_idx(idx, uart_status_pkg::IDX_CONTROL) ? {28'h0000000, control_q} : 32'h00000000;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_q;
  assign prdata_d = (!pwrite && hit) ? rd_word : 32'h00000000;
  assign cfg_wr = wr_en && is_idx(idx, uart_status_pkg::IDX_OUT_CONFIG);
  assign ctrl_wr = wr_en && is_idx(idx, uart_status_pkg::IDX_CONTROL);
  assign output_pin_configuration_d = cfg_wr ? pwdata[7:0] : output_pin_configuration_q;
  assign control_d = ctrl_wr ? pwdata[3:0] : control_q;

  // Read data is captured in the setup cycle so it stands from a flop in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (setup) begin
      prdata_q <= prdata_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_pin_configuration_q <= uart_status_pkg::OPC_RESET;
    end else begin
      output_pin_configuration_q <= output_pin_configuration_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q <= uart_status_pkg::CTRL_RESET;
    end else begin
      control_q <= control_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive status per channel

  uart_status_pkg::chan_events_t ev [uart_status_pkg::CHANNELS];
  assign ev[0] = chan_a;
  assign ev[1] = chan_b;

  for (genvar c = 0; c < uart_status_pkg::CHANNELS; c++) begin : g_chan
    logic [2:0] err_mem_q [DEPTH];
    logic [uart_status_pkg::PTR_W-1:0] rd_ptr_q;
    logic [uart_status_pkg::PTR_W-1:0] wr_ptr_q;
    logic [uart_status_pkg::CNT_W-1:0] cnt_q;
    logic [uart_status_pkg::CNT_W-1:0] cnt_pop;
    logic [uart_status_pkg::CNT_W-1:0] cnt_d;
    logic [uart_status_pkg::CNT_W-1:0] depth;
    logic held_q;
    logic held_d;
    logic [2:0] held_err_q;
    logic [2:0] new_err;
    logic [2:0] wdata;
    logic [2:0] blk_q;
    logic [2:0] shown_err;
    logic full_q;
    logic ready_q;
    logic ovr_q;
    logic cmd_wr;
    logic rx_rst;
    logic err_rst;
    logic legacy;
    logic block_mode;
    logic pop;
    logic space;
    logic wr_held;
    logic new_to_fifo;
    logic new_to_held;
    logic overrun;
    logic wr;
    logic [uart_status_pkg::PTR_W-1:0] rd_ptr_d;
    logic [uart_status_pkg::PTR_W-1:0] wr_ptr_d;
    logic full_d;
    logic ready_d;
    logic ovr_d;
    logic [2:0] blk_d;
    logic [2:0] held_err_d;

    assign cmd_wr = wr_en && is_idx(idx, c == 0 ? uart_status_pkg::IDX_COMMAND_A : uart_status_pkg::IDX_COMMAND_B);
    assign rx_rst = cmd_wr && pwdata[uart_status_pkg::CMD_MSB:uart_status_pkg::CMD_LSB] == uart_status_pkg::CMD_RESET_RX;
    assign err_rst = cmd_wr && pwdata[uart_status_pkg::CMD_MSB:uart_status_pkg::CMD_LSB] == uart_status_pkg::CMD_RESET_ERR;
    assign legacy = control_q[c == 0 ? uart_status_pkg::CTRL_LEGACY_A : uart_status_pkg::CTRL_LEGACY_B];
    assign block_mode = control_q[c == 0 ? uart_status_pkg::CTRL_BLOCK_A : uart_status_pkg::CTRL_BLOCK_B];
    assign depth = legacy ? uart_status_pkg::CNT_W'(LEGACY_DEPTH) : uart_status_pkg::CNT_W'(DEPTH);

    // Read frees a slot first, then the held or the new character may take it
    assign pop = ev[c].rx_read && cnt_q != '0;
    assign cnt_pop = cnt_q - uart_status_pkg::CNT_W'(pop);
    assign space = cnt_pop < depth;
    assign wr_held = held_q && pop;
    assign new_to_fifo = ev[c].rx_load && !wr_held && space;
    assign new_to_held = ev[c].rx_load && !new_to_fifo && (!held_q || wr_held);
    assign overrun = ev[c].rx_load && held_q && !pop;
    assign wr = wr_held || new_to_fifo;
    assign new_err = {ev[c].brk, ev[c].framing, ev[c].parity};
    assign wdata = wr_held ? held_err_q : new_err;
    assign held_d = !rx_rst && (new_to_held || (held_q && !wr_held));
    assign cnt_d = rx_rst ? '0 : cnt_pop + uart_status_pkg::CNT_W'(wr);
    assign rd_ptr_d = rx_rst ? '0 : bump(rd_ptr_q, pop, depth);
    assign wr_ptr_d = rx_rst ? '0 : bump(wr_ptr_q, wr, depth);
    assign full_d = cnt_d == depth;
    assign ready_d = cnt_d != '0;
    assign ovr_d = overrun || (ovr_q && !err_rst && !rx_rst);
    assign blk_d = ((err_rst || rx_rst) ? 3'h0 : blk_q) | (wr ? wdata : 3'h0);
    assign held_err_d = (new_to_held && !rx_rst) ? new_err : ((err_rst || rx_rst) ? 3'h0 : held_err_q);

    // Receiver reset is folded into each next value, so every flop below except the error memory has one job
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_d;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rd_ptr_q <= '0;
      end else begin
        rd_ptr_q <= rd_ptr_d;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        wr_ptr_q <= '0;
      end else begin
        wr_ptr_q <= wr_ptr_d;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        held_q <= 1'b0;
      end else begin
        held_q <= held_d;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        full_q <= 1'b0;
      end else begin
        full_q <= full_d;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ready_q <= 1'b0;
      end else begin
        ready_q <= ready_d;
      end
    end

    // Error memory: either reset command drops stored status; an arrival in an error-reset cycle still lands, one in a receiver-reset cycle does not
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        for (int i = 0; i < DEPTH; i++) begin
          err_mem_q[i] <= 3'h0;
        end
      end else begin
        if (err_rst || rx_rst) begin
          for (int i = 0; i < DEPTH; i++) begin
            err_mem_q[i] <= 3'h0;
          end
        end
        if (wr && !rx_rst) begin
          err_mem_q[wr_ptr_q] <= wdata;
        end
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        held_err_q <= 3'h0;
      end else begin
        held_err_q <= held_err_d;
      end
    end

    // Sticky flags: an event in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ovr_q <= 1'b0;
      end else begin
        ovr_q <= ovr_d;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        blk_q <= 3'h0;
      end else begin
        blk_q <= blk_d;
      end
    end

    assign shown_err = block_mode ? blk_q : (ready_q ? err_mem_q[rd_ptr_q] : 3'h0);

    // Same layout for both channels
    always_comb begin
      status_q[c] = 8'h00;
      status_q[c][7:uart_status_pkg::ST_ERR_LSB] = shown_err;
      status_q[c][uart_status_pkg::ST_OVERRUN] = ovr_q;
      status_q[c][uart_status_pkg::ST_TX_EMPTY] = ev[c].tx_drained;
      status_q[c][uart_status_pkg::ST_TX_SPACE] = ev[c].tx_space;
      status_q[c][uart_status_pkg::ST_RX_FULL] = full_q;
      status_q[c][uart_status_pkg::ST_RX_READY] = ready_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pin selection

  logic [7:0] inv_latch;
  logic [1:0] sel3;
  logic [1:0] sel2;
  uart_status_pkg::pin_drive_t drive_d;
  uart_status_pkg::pin_drive_t drive_q;
  logic [1:0] pin7_drv;
  logic [1:0] pin6_drv;
  logic [1:0] pin5_drv;
  logic [1:0] pin4_drv;

  assign inv_latch = ~output_value_latch;
  assign sel3 = output_pin_configuration_q[uart_status_pkg::OPC_PIN3_LSB +: 2];
  assign sel2 = output_pin_configuration_q[uart_status_pkg::OPC_PIN2_LSB +: 2];

  // Open-drain pins only ever pull low; enable tracks the low level
  function automatic logic [1:0] pick(input logic sel, input logic latch_lvl, input logic irq_raw);
    return sel ? {1'b0, irq_raw} : {latch_lvl, 1'b1};
  endfunction

  // Raw status bypasses the mask, so a masked source still pulls its pin low
  assign pin7_drv = pick(output_pin_configuration_q[uart_status_pkg::OPC_PIN7],
    inv_latch[7], irq_status_bits[uart_status_pkg::IRQ_TX_B]);
  assign pin6_drv = pick(output_pin_configuration_q[uart_status_pkg::OPC_PIN6],
    inv_latch[6], irq_status_bits[uart_status_pkg::IRQ_TX_A]);
  assign pin5_drv = pick(output_pin_configuration_q[uart_status_pkg::OPC_PIN5],
    inv_latch[5], irq_status_bits[uart_status_pkg::IRQ_RX_B]);
  assign pin4_drv = pick(output_pin_configuration_q[uart_status_pkg::OPC_PIN4],
    inv_latch[4], irq_status_bits[uart_status_pkg::IRQ_RX_A]);

  always_comb begin
    drive_d.level = 8'h00;
    drive_d.oe = 8'hFF;
    drive_d.level[1:0] = low_pin_level;
    {drive_d.level[7], drive_d.oe[7]} = pin7_drv;
    {drive_d.level[6], drive_d.oe[6]} = pin6_drv;
    {drive_d.level[5], drive_d.oe[5]} = pin5_drv;
    {drive_d.level[4], drive_d.oe[4]} = pin4_drv;
    case (sel3)
      uart_status_pkg::SEL_LATCH: drive_d.level[3] = inv_latch[3];
      uart_status_pkg::SEL_ALT1: begin
        drive_d.level[3] = 1'b0;
        drive_d.oe[3] = !pin_src.ct_out;
      end
      uart_status_pkg::SEL_ALT2: drive_d.level[3] = pin_src.tx_b_1x;
      default: drive_d.level[3] = pin_src.rx_b_1x;
    endcase
    case (sel2)
      uart_status_pkg::SEL_LATCH: drive_d.level[2] = inv_latch[2];
      uart_status_pkg::SEL_ALT1: drive_d.level[2] = pin_src.tx_a_16x;
      uart_status_pkg::SEL_ALT2: drive_d.level[2] = pin_src.tx_a_1x;
      default: drive_d.level[2] = pin_src.rx_a_1x;
    endcase
  end

  // Registered pins add one cycle of latency but keep the pads glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_q <= '0;
    end else begin
      drive_q <= drive_d;
    end
  end

  assign general_out_pin_o = drive_q.level;
  assign general_out_pin_oe = drive_q.oe;

endmodule // uart_status_and_output_select

// *** uart_status_pkg.sv ***
package uart_status_pkg;

  localparam int CHANNELS = 2;
  localparam int DEPTH_FULL = 16;
  localparam int DEPTH_LEGACY = 8;
  localparam int CNT_W = 5;
  localparam int PTR_W = 4;

  // Register indices; the byte address is four times the index
  localparam logic [5:0] IDX_STATUS_A = 6'h01;
  localparam logic [5:0] IDX_COMMAND_A = 6'h02;
  localparam logic [5:0] IDX_STATUS_B = 6'h09;
  localparam logic [5:0] IDX_COMMAND_B = 6'h0A;
  localparam logic [5:0] IDX_OUT_CONFIG = 6'h0D;
  localparam logic [5:0] IDX_CONTROL = 6'h10;

  // Command register field and codes
  localparam int CMD_MSB = 7;
  localparam int CMD_LSB = 4;
  localparam logic [3:0] CMD_RESET_RX = 4'h2;
  localparam logic [3:0] CMD_RESET_ERR = 4'h4;

  // Control register: per channel legacy depth and block error mode
  localparam int CTRL_LEGACY_A = 0;
  localparam int CTRL_BLOCK_A = 1;
  localparam int CTRL_LEGACY_B = 2;
  localparam int CTRL_BLOCK_B = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // Status byte layout
  localparam int ST_ERR_LSB = 5;
  localparam int ST_OVERRUN = 4;
  localparam int ST_TX_EMPTY = 3;
  localparam int ST_TX_SPACE = 2;
  localparam int ST_RX_FULL = 1;
  localparam int ST_RX_READY = 0;

  // Output configuration fields
  localparam int OPC_PIN7 = 7;
  localparam int OPC_PIN6 = 6;
  localparam int OPC_PIN5 = 5;
  localparam int OPC_PIN4 = 4;
  localparam int OPC_PIN3_LSB = 2;
  localparam int OPC_PIN2_LSB = 0;
  localparam logic [7:0] OPC_RESET = 8'h00;
  localparam logic [1:0] SEL_LATCH = 2'h0;
  localparam logic [1:0] SEL_ALT1 = 2'h1;
  localparam logic [1:0] SEL_ALT2 = 2'h2;

  // Interrupt status bit positions routed to pins
  localparam int IRQ_TX_B = 4;
  localparam int IRQ_TX_A = 0;
  localparam int IRQ_RX_B = 5;
  localparam int IRQ_RX_A = 1;

  typedef struct packed {
    logic rx_load;
    logic brk;
    logic framing;
    logic parity;
    logic rx_read;
    logic tx_drained;
    logic tx_space;
  } chan_events_t;

  typedef struct packed {
    logic ct_out;
    logic tx_b_1x;
    logic rx_b_1x;
    logic tx_a_16x;
    logic tx_a_1x;
    logic rx_a_1x;
  } pin_sources_t;

  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe;
  } pin_drive_t;

endpackage

// *** uart_status_props.sv ***
`timescale 1ns/1ps
module uart_status_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire uart_status_pkg::chan_events_t chan_a,
  input wire uart_status_pkg::chan_events_t chan_b,
  input wire logic [7:0] output_value_latch,
  input wire logic [7:0] irq_status_bits,
  input wire logic [1:0] low_pin_level,
  input wire uart_status_pkg::pin_sources_t pin_src,
  input wire logic [7:0] general_out_pin_o,
  input wire logic [7:0] general_out_pin_oe
);
  ////////////////////////////////////////
  // Shadow copy, since the configuration cannot be read back
  logic [7:0] cfg_q;
  wire logic cfg_wr = psel && penable && pwrite && paddr == 8'h34;
  wire logic [7:0] cfg_d = cfg_wr ? pwdata[7:0] : cfg_q;
  wire logic [3:0] irq_map = {irq_status_bits[4], irq_status_bits[0], irq_status_bits[5], irq_status_bits[1]};
  wire logic [1:0] exp3 = cfg_q[3:2] == 2'h0 ? {~output_value_latch[3], 1'b1} : cfg_q[3:2] == 2'h1 ?
    {1'b0, ~pin_src.ct_out} : {cfg_q[2] ? pin_src.rx_b_1x : pin_src.tx_b_1x, 1'b1};
  wire logic exp2 = cfg_q[1:0] == 2'h0 ? ~output_value_latch[2] : cfg_q[1:0] == 2'h1 ? pin_src.tx_a_16x :
    cfg_q[0] ? pin_src.rx_a_1x : pin_src.tx_a_1x;
  wire logic mapped = paddr inside {8'h04, 8'h08, 8'h24, 8'h28, 8'h34, 8'h40};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cfg_q <= 8'h00;
    else cfg_q <= cfg_d;
  end
  ////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_quiet_b; !chan_b.rx_read && !(psel && penable && pwrite); endsequence
  sequence s_load_b; chan_b.rx_load ##0 s_quiet_b; endsequence
  sequence s_read_b; psel && !penable && !pwrite && paddr == 8'h24; endsequence
  a_default_inverted: assert property (cfg_q == 8'h00 |=>
    general_out_pin_o[7:2] == ~$past(output_value_latch[7:2]) && general_out_pin_oe[7:2] == 6'h3F)
    else $error("pins not showing inverted latch");
  a_low_pins_pass: assert property (1'b1 |=>
    general_out_pin_o[1:0] == $past(low_pin_level) && general_out_pin_oe[1:0] == 2'h3)
    else $error("low pins wrong");
  a_irq_open_drain: assert property (1'b1 |=>
    general_out_pin_oe[7:4] == $past(~cfg_q[7:4] | irq_map)) else $error("irq pin enable wrong");
  a_irq_level_low: assert property (1'b1 |=>
    general_out_pin_o[7:4] == $past(~cfg_q[7:4] & ~output_value_latch[7:4])) else $error("irq pin level wrong");
  a_pin3_select: assert property (1'b1 |=> {general_out_pin_o[3], general_out_pin_oe[3]} == $past(exp3))
    else $error("pin 3 select wrong");
  a_pin2_select: assert property (1'b1 |=> general_out_pin_o[2] == $past(exp2) && general_out_pin_oe[2])
    else $error("pin 2 select wrong");
  a_rx_ready_set: assert property (s_load_b ##1 s_quiet_b ##1 s_read_b |=> prdata[0] && prdata[31:8] == 24'h0)
    else $error("ready not set after load");
  a_tx_live_bits: assert property (s_read_b |=>
    prdata[3] == $past(chan_b.tx_drained) && prdata[2] == $past(chan_b.tx_space)) else $error("tx bits wrong");
  a_bus_error: assert property (psel && penable |-> pready && pslverr == !mapped)
    else $error("error response wrong");
endmodule // uart_status_props
